// *** vcp_link_if.sv ***
`timescale 1ns/10ps

// words and events crossing between the system clock and the bit clock
interface vcp_link_if;
    vcp_pkg::vcp_code_t txWord;
    logic txToggle;
    vcp_pkg::vcp_code_t rxWord;
    logic rxToggle;
    logic frameBusMode;

    modport core (
        output txWord,
        output txToggle,
        output frameBusMode,
        input rxWord,
        input rxToggle
    );

    modport link (
        input txWord,
        input txToggle,
        input frameBusMode,
        output rxWord,
        output rxToggle
    );
endinterface : vcp_link_if

// *** vcp_link_partner.sv ***
`timescale 1ns/10ps

// far-end transceiver: free-running bit clock, slot strobe and rx data
module vcp_link_partner (
    output logic deviceClockIn,
    output logic slotStrobeIn,
    output logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    input wire logic delayedStrobeOut
);
    // 781 bits of 160 ns make one 125 us frame
    localparam int FRAME_BITS = 781;

    // odd start offset keeps the bit clock out of phase with clk
    initial begin
        deviceClockIn = 1'b0;
        slotStrobeIn = 1'b0;
        serialDataIn = 1'b0;
        #13;
        forever #80 deviceClockIn = ~deviceClockIn;
    end

    // one frame: 8-bit high strobe, msb first, then idle until frame end
    task run_frame(input logic [7:0] rxByte, output logic [7:0] txByte,
                   output int oeBits, output int dsBits);
        int i;
        txByte = 8'h00;
        oeBits = 0;
        dsBits = 0;
        @(posedge deviceClockIn);
        #5;
        for (i = 0; i < 9; i++) begin
            slotStrobeIn = (i < 8);
            // idle data shows the inverse, never a stale bit
            serialDataIn = (i < 8) ? rxByte[7 - i] : ~rxByte[0];
            @(negedge deviceClockIn);
            if (serialDataOe === 1'b1) begin
                txByte = {txByte[6:0], serialDataOut};
                oeBits++;
            end
            @(posedge deviceClockIn);
            #5;
        end
        // look after the launching edge has settled, from the edge that
        // first sees the strobe low; the task's own opening edge ends it
        for (i = 0; i < FRAME_BITS - 10; i++) begin
            if (delayedStrobeOut === 1'b1) dsBits++;
            if (serialDataOe === 1'b1) oeBits++;
            serialDataIn = ~serialDataIn;
            @(posedge deviceClockIn);
            #5;
        end
    endtask : run_frame
endmodule : vcp_link_partner

// *** vcp_params.svh ***
`ifndef VCP_PARAMS_SVH
`define VCP_PARAMS_SVH

// register offsets on the control port
`define VCP_ADDR_PATH_GAIN 3'h0
`define VCP_ADDR_SIDETONE 3'h1
`define VCP_ADDR_MUTE 3'h3
`define VCP_ADDR_LAW_PORT 3'h4

// reset values: every gain step zero, side tone off, mu-law, ITU coding
`define VCP_RST_PATH_GAIN 8'h00
`define VCP_RST_SIDETONE 8'h00
`define VCP_RST_MUTE 8'h00
`define VCP_RST_LAW_PORT 8'h00

// field positions
`define VCP_TXG_LSB 0
`define VCP_TXG_MSB 2
`define VCP_RXG_LSB 4
`define VCP_RXG_MSB 6
`define VCP_STG_LSB 0
`define VCP_STG_MSB 2
`define VCP_STEN_BIT 3
`define VCP_TXMUTE_BIT 0
`define VCP_RXMUTE_BIT 1
`define VCP_LAWA_BIT 0
`define VCP_SMAG_BIT 1
`define VCP_DEN_BIT 2
`define VCP_MODE_LSB 3
`define VCP_MODE_MSB 5
`define VCP_EFFLAW_BIT 7

// port mode encodings
`define VCP_MODE_SSI 3'h0
`define VCP_MODE_FRAME_BUS 3'h7

// code assignment masks and quiet code
`define VCP_MU_INVERT 8'h7F
`define VCP_A_INVERT 8'h55
`define VCP_QUIET_SMAG 8'h00

// link timing in bit clocks: one slot, and four channel slots
`define VCP_SLOT_BITS 6'h08
`define VCP_FP_DELAY 6'h20

`endif

// *** vcp_pcm_control.sv ***
`timescale 1ns/10ps
`include "vcp_params.svh"

// Operation
// - receive bits sampled on falling bit clock
// - transmit bits driven on rising edges, else off
// - cascade output: delayed strobe or delayed frame pulse
// - reset: side tone off, gains 0 dB, mu-law
// - reset: strobed serial mode, port powered up
// - three-bit tx and rx filter gains at 00h
// - three-bit side-tone gain field at 01h
// - side-tone on/off bit at 01h, independent
// - A-law when register bit or pin is set
// - law pin becomes open-drain interrupt when enabled
// - format bit picks ITU or sign-magnitude coding
// - ITU: A-law alternate inversion, mu-law inverted magnitude
// - muted path carries the negative-zero quiet code
// - one eight-bit word per frame per direction
// - works from reset defaults without any writes
module vcp_pcm_control #(
    parameter bit CASCADE = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic deviceClockIn,
    input wire logic slotStrobeIn,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic delayedStrobeOut,
    input wire logic lawPinIn,
    output logic lawPinOut,
    output logic lawPinOe,
    input wire logic dchannelIrqRequest,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic [7:0] txSample,
    input wire logic txSampleLoad,
    output logic [7:0] rxSample,
    output logic rxSampleValid,
    output logic [2:0] txFilterGain,
    output logic [2:0] rxFilterGain,
    output logic [2:0] sidetoneGain,
    output logic sidetoneEnable,
    output logic aLawSelect,
    output logic codeFormatSelect,
    output logic frameBusMode
);
    logic [7:0] pathGainControl;
    logic [7:0] sidetoneGainControl;
    logic [7:0] muteControl;
    logic [7:0] lawAndPortControl;
    logic lawPinMeta, lawPinSync;
    logic rxTogMeta, rxTogSync, rxTogSeen;
    logic rxEvent;
    logic dchannelEnable;
    logic next_aLaw;
    logic [7:0] txLast;
    logic [7:0] next_txWord;
    logic [2:0] portMode;

    vcp_link_if lnk ();

    // convert between sign-magnitude and the selected line code; the
    // mapping is its own inverse, so one function serves both directions
    function automatic vcp_pkg::vcp_code_t code_map(
        input vcp_pkg::vcp_code_t word,
        input logic useALaw,
        input logic useSmag
    );
        vcp_pkg::vcp_code_t mapped;
        if (useSmag) begin
            mapped = word;
        end else if (useALaw) begin
            mapped = word ^ `VCP_A_INVERT;
        end else begin
            mapped = word ^ `VCP_MU_INVERT;
        end
        return mapped;
    endfunction : code_map

    // true when the address hits one of the four registers
    function automatic logic is_mapped(input logic [2:0] addr);
        return (addr == `VCP_ADDR_PATH_GAIN) || (addr == `VCP_ADDR_SIDETONE)
            || (addr == `VCP_ADDR_MUTE) || (addr == `VCP_ADDR_LAW_PORT);
    endfunction : is_mapped

    // law pin is asynchronous to clk, two flops before anything reads it
    always_ff @(posedge clk) begin
        lawPinMeta <= lawPinIn;
        lawPinSync <= lawPinMeta;
    end

    // receive toggle from the bit clock domain, synchronised then edged
    always_ff @(posedge clk) begin
        if (rst) begin
            rxTogMeta <= 1'b0;
            rxTogSync <= 1'b0;
            rxTogSeen <= 1'b0;
        end else begin
            rxTogMeta <= lnk.rxToggle;
            rxTogSync <= rxTogMeta;
            rxTogSeen <= rxTogSync;
        end
    end

    assign rxEvent = rxTogSync ^ rxTogSeen;

    // gain register: tx and rx filter steps; no write needed to run
    always_ff @(posedge clk) begin
        if (rst) begin
            pathGainControl <= `VCP_RST_PATH_GAIN;
        end else if (regWrite && regAddr == `VCP_ADDR_PATH_GAIN) begin
            pathGainControl <= regWrData;
        end
    end

    // side-tone register: gain steps and the path switch
    always_ff @(posedge clk) begin
        if (rst) begin
            sidetoneGainControl <= `VCP_RST_SIDETONE;
        end else if (regWrite && regAddr == `VCP_ADDR_SIDETONE) begin
            sidetoneGainControl <= regWrData;
        end
    end

    // mute register for both paths
    always_ff @(posedge clk) begin
        if (rst) begin
            muteControl <= `VCP_RST_MUTE;
        end else if (regWrite && regAddr == `VCP_ADDR_MUTE) begin
            muteControl <= regWrData;
        end
    end

    // law, format, interrupt enable and port mode
    always_ff @(posedge clk) begin
        if (rst) begin
            lawAndPortControl <= `VCP_RST_LAW_PORT;
        end else if (regWrite && regAddr == `VCP_ADDR_LAW_PORT) begin
            lawAndPortControl <= regWrData;
        end
    end

    assign dchannelEnable = lawAndPortControl[`VCP_DEN_BIT];
    assign portMode = lawAndPortControl[`VCP_MODE_MSB:`VCP_MODE_LSB];

    // the pin only counts as a law input while the interrupt is disabled
    always_comb begin
        next_aLaw = lawAndPortControl[`VCP_LAWA_BIT]
            | (lawPinSync & ~dchannelEnable);
    end

    // analog controls; gains leave as raw step counts, zero is nominal
    always_ff @(posedge clk) begin
        if (rst) begin
            txFilterGain <= 3'h0;
            rxFilterGain <= 3'h0;
            sidetoneGain <= 3'h0;
            sidetoneEnable <= 1'b0;
            aLawSelect <= 1'b0;
            codeFormatSelect <= 1'b0;
            frameBusMode <= 1'b0;
        end else begin
            txFilterGain <= pathGainControl[`VCP_TXG_MSB:`VCP_TXG_LSB];
            rxFilterGain <= pathGainControl[`VCP_RXG_MSB:`VCP_RXG_LSB];
            sidetoneGain <= sidetoneGainControl[`VCP_STG_MSB:`VCP_STG_LSB];
            sidetoneEnable <= sidetoneGainControl[`VCP_STEN_BIT];
            aLawSelect <= next_aLaw;
            codeFormatSelect <= lawAndPortControl[`VCP_SMAG_BIT];
            frameBusMode <= (portMode == `VCP_MODE_FRAME_BUS);
        end
    end

    // open-drain interrupt: only ever pulls low, never drives high
    always_ff @(posedge clk) begin
        if (rst) begin
            lawPinOe <= 1'b0;
        end else begin
            lawPinOe <= dchannelEnable & dchannelIrqRequest;
        end
    end

    assign lawPinOut = 1'b0;

    // register reads answer one cycle later; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRead;
            if (regRead) begin
                case (regAddr)
                    `VCP_ADDR_PATH_GAIN: regRdData <= pathGainControl;
                    `VCP_ADDR_SIDETONE: regRdData <= sidetoneGainControl;
                    `VCP_ADDR_MUTE: regRdData <= muteControl;
                    `VCP_ADDR_LAW_PORT: begin
                        regRdData <= {next_aLaw,
                            lawAndPortControl[`VCP_EFFLAW_BIT - 1:0]};
                    end
                    default: regRdData <= 8'h00;
                endcase
            end
        end
    end

    // latest transmit sample from the encoder, kept in sign-magnitude
    always_ff @(posedge clk) begin
        if (rst) begin
            txLast <= `VCP_QUIET_SMAG;
        end else if (txSampleLoad) begin
            txLast <= txSample;
        end
    end

    // line word for the next slot; mute swaps in negative zero
    always_comb begin
        if (muteControl[`VCP_TXMUTE_BIT]) begin
            next_txWord = code_map(`VCP_QUIET_SMAG, next_aLaw,
                lawAndPortControl[`VCP_SMAG_BIT]);
        end else begin
            next_txWord = code_map(txLast, next_aLaw,
                lawAndPortControl[`VCP_SMAG_BIT]);
        end
    end

    // one transmit word per frame; posting right after each receive event
    // keeps the handshake far from the next slot so the word is settled
    always_ff @(posedge clk) begin
        if (rst) begin
            lnk.txWord <= `VCP_QUIET_SMAG;
            lnk.txToggle <= 1'b0;
        end else if (rxEvent) begin
            lnk.txWord <= next_txWord;
            lnk.txToggle <= ~lnk.txToggle;
        end
    end

    assign lnk.frameBusMode = frameBusMode;

    // decode the received line word into sign-magnitude for the decoder
    always_ff @(posedge clk) begin
        if (rst) begin
            rxSample <= `VCP_QUIET_SMAG;
            rxSampleValid <= 1'b0;
        end else begin
            rxSampleValid <= rxEvent;
            if (rxEvent && muteControl[`VCP_RXMUTE_BIT]) begin
                rxSample <= `VCP_QUIET_SMAG;
            end else if (rxEvent) begin
                rxSample <= code_map(lnk.rxWord, next_aLaw,
                    lawAndPortControl[`VCP_SMAG_BIT]);
            end
        end
    end

    // bit clock side: strobe, shifters and cascade output
    vcp_serial_slot #(
        .CASCADE(CASCADE)
    ) u_slot (
        .deviceClockIn(deviceClockIn),
        .rst(rst),
        .slotStrobeIn(slotStrobeIn),
        .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe),
        .delayedStrobeOut(delayedStrobeOut),
        .lnk(lnk.link)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_rx_event;
        rxEvent;
    endsequence

    sequence s_rx_muted;
        rxEvent && muteControl[`VCP_RXMUTE_BIT];
    endsequence

    chk_reset_defaults_out: assert property (
        $fell(rst) |-> pathGainControl == `VCP_RST_PATH_GAIN
            && sidetoneGainControl == `VCP_RST_SIDETONE
            && lawAndPortControl == `VCP_RST_LAW_PORT)
        else $error("register defaults wrong after reset");
    chk_reset_outputs: assert property (
        $fell(rst) |=> !sidetoneEnable && !aLawSelect && !frameBusMode
            && txFilterGain == 3'h0 && rxFilterGain == 3'h0)
        else $error("controls not at defaults after reset");
    chk_law_or_pin: assert property (
        ##1 aLawSelect == $past(next_aLaw))
        else $error("effective law is not register or pin");
    chk_irq_open_drain: assert property (
        !dchannelEnable |=> !lawPinOe) else $error("law pin driven as input");
    chk_rx_quiet_code: assert property (
        s_rx_muted |=> rxSampleValid && rxSample == `VCP_QUIET_SMAG)
        else $error("muted receive not quiet");
    chk_rx_smag_pass: assert property (
        s_rx_event and (!muteControl[`VCP_RXMUTE_BIT]
            && lawAndPortControl[`VCP_SMAG_BIT])
        |=> rxSample == $past(lnk.rxWord))
        else $error("sign-magnitude receive altered");
    chk_rx_mu_invert: assert property (
        s_rx_event and (!muteControl[`VCP_RXMUTE_BIT]
            && !lawAndPortControl[`VCP_SMAG_BIT] && !next_aLaw)
        |=> rxSample == ($past(lnk.rxWord) ^ `VCP_MU_INVERT))
        else $error("mu-law magnitude not inverted");
    chk_tx_quiet_alaw: assert property (
        s_rx_event and (muteControl[`VCP_TXMUTE_BIT] && next_aLaw
            && !lawAndPortControl[`VCP_SMAG_BIT])
        |=> lnk.txWord == `VCP_A_INVERT)
        else $error("muted A-law transmit not quiet");
    chk_tx_one_per_frame: assert property (
        s_rx_event |=> $changed(lnk.txToggle))
        else $error("transmit word not posted for frame");
    chk_sidetone_indep: assert property (
        regWrite && regAddr == `VCP_ADDR_PATH_GAIN
        |=> $stable(sidetoneGainControl))
        else $error("gain write touched side tone");
    chk_rd_unmapped_zero: assert property (
        regRead && !is_mapped(regAddr) |=> regRdValid && regRdData == 8'h00)
        else $error("unmapped read not zero");
    // read answers come exactly one cycle after the strobe, never unasked
    chk_rd_valid_next: assert property (
        regRead |=> regRdValid) else $error("read not answered");
    chk_rd_valid_pulse: assert property (
        !regRead |=> !regRdValid) else $error("read valid without read");
    // the other law and the other quiet code, so both arms are watched
    chk_rx_alaw_adi: assert property (
        s_rx_event and (!muteControl[`VCP_RXMUTE_BIT]
            && !lawAndPortControl[`VCP_SMAG_BIT] && next_aLaw)
        |=> rxSample == ($past(lnk.rxWord) ^ `VCP_A_INVERT))
        else $error("A-law digits not inverted");
    chk_tx_quiet_mulaw: assert property (
        s_rx_event and (muteControl[`VCP_TXMUTE_BIT] && !next_aLaw
            && !lawAndPortControl[`VCP_SMAG_BIT])
        |=> lnk.txWord == `VCP_MU_INVERT)
        else $error("muted mu-law transmit not quiet");
endmodule : vcp_pcm_control

// *** vcp_pkg.sv ***
package vcp_pkg;

    // delayed strobe generator states, one-hot
    typedef enum logic [3:0] {
        DS_IDLE = 4'b0001,
        DS_STROBE = 4'b0010,
        DS_WAIT = 4'b0100,
        DS_PULSE = 4'b1000
    } vcp_dstb_state_t;

    typedef logic [7:0] vcp_code_t;

endpackage : vcp_pkg

// *** vcp_serial_slot.sv ***
`timescale 1ns/10ps
`include "vcp_params.svh"

module vcp_serial_slot #(
    parameter bit CASCADE = 1'b1
) (
    input wire logic deviceClockIn,
    input wire logic rst,
    input wire logic slotStrobeIn,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic delayedStrobeOut,
    vcp_link_if.link lnk
);
    logic rstMeta, linkRst, stbPrev, txTogMeta, txTogSync, txTogSeen;
    logic busMeta, busMode;
    logic [7:0] txShift, rxShift;
    logic [5:0] dlyCount;
    vcp_pkg::vcp_dstb_state_t dsState;
    logic stbFall;

    // reset and quasi-static levels pass two flops into the bit clock domain
    always_ff @(posedge deviceClockIn) begin
        rstMeta <= rst;
        linkRst <= rstMeta;
        busMeta <= lnk.frameBusMode;
        busMode <= busMeta;
        txTogMeta <= lnk.txToggle;
        txTogSync <= txTogMeta;
    end

    assign stbFall = stbPrev & ~slotStrobeIn;

    // transmit shifter; the word arrives by toggle so it is settled here
    always_ff @(posedge deviceClockIn) begin
        if (linkRst) begin
            stbPrev <= 1'b0;
            txTogSeen <= 1'b0;
            txShift <= `VCP_MU_INVERT; // negative zero of the reset law
            serialDataOut <= 1'b0;
            serialDataOe <= 1'b0;
        end else begin
            stbPrev <= slotStrobeIn;
            txTogSeen <= txTogSync;
            serialDataOe <= slotStrobeIn;
            if (slotStrobeIn && !stbPrev) begin
                serialDataOut <= txShift[7];
                txShift <= {txShift[6:0], 1'b0};
            end else if (slotStrobeIn) begin
                serialDataOut <= txShift[7];
                txShift <= {txShift[6:0], 1'b0};
            end else if (txTogSync != txTogSeen) begin
                txShift <= lnk.txWord;
            end
        end
    end

    // receive bits are taken on the falling bit clock edge
    always_ff @(negedge deviceClockIn) begin
        if (slotStrobeIn) begin
            rxShift <= {rxShift[6:0], serialDataIn};
        end
    end

    // one word per strobe handed to the core with a toggle
    always_ff @(posedge deviceClockIn) begin
        if (linkRst) begin
            lnk.rxWord <= `VCP_QUIET_SMAG;
            lnk.rxToggle <= 1'b0;
        end else if (stbFall) begin
            lnk.rxWord <= rxShift;
            lnk.rxToggle <= ~lnk.rxToggle;
        end
    end

    // delayed strobe or delayed frame pulse for cascading
    always_ff @(posedge deviceClockIn) begin
        if (linkRst || !CASCADE) begin
            dsState <= vcp_pkg::DS_IDLE;
            dlyCount <= 6'h00;
            delayedStrobeOut <= 1'b0;
        end else begin
            case (dsState)
                vcp_pkg::DS_IDLE: begin
                    delayedStrobeOut <= busMode;
                    if (stbFall && !busMode) begin
                        dsState <= vcp_pkg::DS_STROBE;
                        dlyCount <= `VCP_SLOT_BITS - 6'h01;
                        delayedStrobeOut <= 1'b1;
                    end else if (stbFall) begin
                        dsState <= vcp_pkg::DS_WAIT;
                        dlyCount <= `VCP_FP_DELAY - 6'h01;
                    end
                end
                vcp_pkg::DS_STROBE: begin
                    if (dlyCount == 6'h00) begin
                        dsState <= vcp_pkg::DS_IDLE;
                        delayedStrobeOut <= 1'b0;
                    end else begin
                        dlyCount <= dlyCount - 6'h01;
                    end
                end
                vcp_pkg::DS_WAIT: begin
                    if (dlyCount == 6'h00) begin
                        dsState <= vcp_pkg::DS_PULSE;
                        delayedStrobeOut <= 1'b0;
                    end else begin
                        dlyCount <= dlyCount - 6'h01;
                    end
                end
                vcp_pkg::DS_PULSE: begin
                    dsState <= vcp_pkg::DS_IDLE;
                    delayedStrobeOut <= 1'b1;
                end
                default: begin
                    dsState <= vcp_pkg::DS_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge deviceClockIn); endclocking
    default disable iff (linkRst);

    chk_dout_slot_enable: assert property (
        slotStrobeIn |=> serialDataOe) else $error("dout not driven in slot");
    chk_dstb_eight_wide: assert property (
        stbFall && !busMode && dsState == vcp_pkg::DS_IDLE && CASCADE
        |=> delayedStrobeOut [*8] ##1 !delayedStrobeOut)
        else $error("delayed strobe not eight bits wide");
endmodule : vcp_serial_slot

// *** voice_codec_pcm_control_bench.sv ***
`timescale 1ns/10ps
`include "vcp_params.svh"

module voice_codec_pcm_control_bench;
    logic clk = 1'b0, rst = 1'b1;
    logic devClk, strobe, sdIn, sdOut, sdOe, dStrobe;
    logic lawPinIn = 1'b0, lawPinOut, lawPinOe, irqReq = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00, regRdData, txSample = 8'h00;
    logic regWrite = 1'b0, regRead = 1'b0, txSampleLoad = 1'b0;
    logic [7:0] rxSample;
    logic rxSampleValid, sidetoneEnable, aLawSelect, codeFormatSelect;
    logic regRdValid, frameBusMode;
    logic [2:0] txFilterGain, rxFilterGain, sidetoneGain;
    int failures = 0, tests_run = 0, cycles = 0;

    vcp_pcm_control #(.CASCADE(1'b1)) dut (.clk(clk), .rst(rst),
        .deviceClockIn(devClk), .slotStrobeIn(strobe), .serialDataIn(sdIn),
        .serialDataOut(sdOut), .serialDataOe(sdOe),
        .delayedStrobeOut(dStrobe), .lawPinIn(lawPinIn),
        .lawPinOut(lawPinOut), .lawPinOe(lawPinOe),
        .dchannelIrqRequest(irqReq), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .txSample(txSample), .txSampleLoad(txSampleLoad),
        .rxSample(rxSample), .rxSampleValid(rxSampleValid),
        .txFilterGain(txFilterGain), .rxFilterGain(rxFilterGain),
        .sidetoneGain(sidetoneGain), .sidetoneEnable(sidetoneEnable),
        .aLawSelect(aLawSelect), .codeFormatSelect(codeFormatSelect),
        .frameBusMode(frameBusMode));

    vcp_link_partner partner (.deviceClockIn(devClk), .slotStrobeIn(strobe),
        .serialDataIn(sdIn), .serialDataOut(sdOut), .serialDataOe(sdOe),
        .delayedStrobeOut(dStrobe));

    always #20 clk = ~clk;

    // hang guard: the planned run needs about 28k cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            $display("BAD %0t timeout", $time);
            tally_and_finish();
        end
    end

    task check_val(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check_val

    task reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(posedge clk);
        #2 regWrite = 1'b0;
    endtask : reg_write

    // valid is awaited a bounded number of edges
    task reg_read(input logic [2:0] a, output logic [7:0] d);
        int n;
        @(posedge clk);
        #2 regAddr = a;
        regRead = 1'b1;
        @(posedge clk);
        #2 regRead = 1'b0;
        for (n = 0; n < 3 && regRdValid !== 1'b1; n++) @(posedge clk) #1;
        check_val({7'h00, regRdValid}, 8'h01);
        d = regRdData;
    endtask : reg_read

    task settle();
        repeat (3) @(posedge clk);
        #2;
    endtask : settle

    task test_defaults();
        logic [7:0] d;
        reg_read(`VCP_ADDR_PATH_GAIN, d); check_val(d, 8'h00);
        reg_read(`VCP_ADDR_SIDETONE, d); check_val(d, 8'h00);
        reg_read(`VCP_ADDR_LAW_PORT, d); check_val(d, 8'h00);
        reg_read(3'h2, d); check_val(d, 8'h00);
        check_val({txFilterGain, rxFilterGain, sidetoneEnable, aLawSelect},
                  8'h00);
        check_val({3'h0, sidetoneGain, codeFormatSelect, frameBusMode},
                  8'h00);
    endtask : test_defaults

    task test_gains();
        logic [7:0] d;
        reg_write(`VCP_ADDR_PATH_GAIN, 8'h75);
        reg_write(`VCP_ADDR_SIDETONE, 8'h0B);
        settle();
        check_val({2'h0, txFilterGain, rxFilterGain}, 8'h2F);
        check_val({4'h0, sidetoneEnable, sidetoneGain}, 8'h0B);
        reg_read(`VCP_ADDR_PATH_GAIN, d); check_val(d, 8'h75);
        // side tone off must leave the filter gains alone
        reg_write(`VCP_ADDR_SIDETONE, 8'h03);
        settle();
        check_val({4'h0, sidetoneEnable, sidetoneGain}, 8'h03);
        check_val({2'h0, txFilterGain, rxFilterGain}, 8'h2F);
    endtask : test_gains

    task test_law_pin();
        logic [7:0] d;
        lawPinIn = 1'b1;
        settle();
        check_val({7'h00, aLawSelect}, 8'h01);
        reg_read(`VCP_ADDR_LAW_PORT, d); check_val(d, 8'h80);
        reg_write(`VCP_ADDR_LAW_PORT, 8'h04);
        irqReq = 1'b1;
        settle();
        check_val({6'h00, aLawSelect, lawPinOut}, 8'h00);
        check_val({7'h00, lawPinOe}, 8'h01);
        irqReq = 1'b0;
        lawPinIn = 1'b0;
        reg_write(`VCP_ADDR_LAW_PORT, 8'h00);
        settle();
        check_val({7'h00, lawPinOe}, 8'h00);
    endtask : test_law_pin

    // two frames: rx converts at once, tx word goes out next frame
    task run_pair(input logic [7:0] smp, input logic [7:0] rxEx,
                  input logic [7:0] txEx);
        logic [7:0] tx;
        int oeBits, dsBits;
        @(posedge clk);
        #2 txSample = smp;
        txSampleLoad = 1'b1;
        @(posedge clk);
        #2 txSampleLoad = 1'b0;
        partner.run_frame(8'hC6, tx, oeBits, dsBits);
        check_val(rxSample, rxEx);
        partner.run_frame(8'hC6, tx, oeBits, dsBits);
        check_val(tx, txEx);
        check_val(oeBits[7:0], 8'h08);
        check_val(dsBits[7:0], 8'h08);
    endtask : run_pair

    task test_coding();
        logic [7:0] mask [3];
        int k;
        mask = '{8'h7F, 8'h55, 8'h00};
        for (k = 0; k < 3; k++) begin
            reg_write(`VCP_ADDR_LAW_PORT, k[7:0]);
            run_pair(8'hA3, 8'hC6 ^ mask[k], 8'hA3 ^ mask[k]);
            check_val({6'h00, codeFormatSelect, aLawSelect},
                      k[7:0]);
        end
        // both muted: decoder gets sign-magnitude zero, line gets mu quiet
        reg_write(`VCP_ADDR_LAW_PORT, 8'h00);
        reg_write(`VCP_ADDR_MUTE, 8'h03);
        run_pair(8'hA3, 8'h00, 8'h7F);
        reg_write(`VCP_ADDR_MUTE, 8'h00);
    endtask : test_coding

    // frame bus: output idles high, low one bit 32 bits after the strobe
    task test_frame_bus();
        logic [7:0] tx;
        int oeBits, dsBits;
        reg_write(`VCP_ADDR_LAW_PORT, 8'h38);
        settle();
        check_val({7'h00, frameBusMode}, 8'h01);
        partner.run_frame(8'h5A, tx, oeBits, dsBits);
        check_val({7'h00, dsBits == 770}, 8'h01);
        check_val(oeBits[7:0], 8'h08);
        reg_write(`VCP_ADDR_LAW_PORT, 8'h00);
    endtask : test_frame_bus

    task tally_and_finish();
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20) @(posedge clk);
        #2 rst = 1'b0;
        test_defaults();
        test_gains();
        test_law_pin();
        test_coding();
        test_frame_bus();
        tally_and_finish();
    end
endmodule : voice_codec_pcm_control_bench
